/* File: rtl/nvm_access_ctrl.sv */
`timescale 1ns/100ps
`include "nvm_access_defines.svh"
module nvm_access_ctrl import nvm_access_pkg::*; (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic por_n_in,
   input wire logic ce_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic irq_out,
   output logic irq_high_out,
   output logic irq_low_out,
   output logic cpu_stall_out,
   output logic prog_wr_out,
   output logic prog_erase_out,
   output logic prog_cfg_out,
   output logic [21:0] prog_addr_out,
   output logic [7:0] prog_data_out
);

   logic rst_n;
   logic acc, wr_acc, rd_setup, mapped;
   logic [7:0] wbyte, rbyte;
   logic sel_ctl, sel_unlock, sel_data, sel_addr, sel_core, sel_prio;
   logic sel_en2, sel_flag2, sel_tlat, sel_plow, sel_phigh, sel_pup;
   logic sel_stat, sel_mask;
   logic prog_sel_reg, cfg_sel_reg, row_erase_reg, wr_err_reg;
   logic wr_allow_reg, wr_start_reg, rd_start_reg;
   logic [7:0] data_reg, addr_reg, core_reg, prio_reg, en2_reg, flag2_reg;
   logic [7:0] tlat_reg, plow_reg, phigh_reg, pup_reg;
   logic [1:0] stat_reg, mask_reg;
   logic [31:0] prdata_reg;
   logic [7:0] mem [0:255];
   logic [7:0] rd_byte;
   unlock_state_e ul_state;
   op_state_e op_state;
   logic [15:0] timer_reg;
   logic [7:0] op_addr_reg, op_data_reg;
   logic op_data_space_reg;
   logic stall_reg, pwr_reg, perase_reg, pcfg_reg;
   logic [21:0] paddr_reg;
   logic [7:0] pdata_reg;
   logic wr_req, wr_go, wr_bad, rd_go, done, go_data, key_first, key_second;
   logic [1:0] events;
   logic write_done_cond;

   assign rst_n = arst_n_in & por_n_in;
   assign pready_out = ce_in;
   assign acc = psel_in & penable_in & ce_in;
   assign wr_acc = acc & pwrite_in;
   assign rd_setup = psel_in & ~penable_in & ~pwrite_in & ce_in;
   assign wbyte = pwdata_in[7:0];

   assign sel_ctl = paddr_in == `OFF_CONTROL;
   assign sel_unlock = paddr_in == `OFF_UNLOCK;
   assign sel_data = paddr_in == `OFF_DATA;
   assign sel_addr = paddr_in == `OFF_ADDR;
   assign sel_core = paddr_in == `OFF_CORE_IRQ;
   assign sel_prio = paddr_in == `OFF_PRIO_TWO;
   assign sel_en2 = paddr_in == `OFF_ENABLE_TWO;
   assign sel_flag2 = paddr_in == `OFF_FLAG_TWO;
   assign sel_tlat = paddr_in == `OFF_TABLE_LATCH;
   assign sel_plow = paddr_in == `OFF_PTR_LOW;
   assign sel_phigh = paddr_in == `OFF_PTR_HIGH;
   assign sel_pup = paddr_in == `OFF_PTR_UPPER;
   assign sel_stat = paddr_in == `OFF_IRQ_STATUS;
   assign sel_mask = paddr_in == `OFF_IRQ_MASK;
   assign mapped = sel_ctl | sel_unlock | sel_data | sel_addr | sel_core |
                   sel_prio | sel_en2 | sel_flag2 | sel_tlat | sel_plow |
                   sel_phigh | sel_pup | sel_stat | sel_mask;
   assign pslverr_out = psel_in & penable_in & ~mapped;

   // start requests from a control write
   assign wr_req = wr_acc & sel_ctl & wbyte[`CTL_WR_START] &
                   ~wr_start_reg & (op_state == op_idle);
   assign wr_go = wr_req & (ul_state == ul_armed) &
                  wr_allow_reg;
   assign wr_bad = wr_req & ~wr_go;
   assign rd_go = wr_acc & sel_ctl & wbyte[`CTL_RD_START] &
                  ~wbyte[`CTL_PROG_SEL] & ~wbyte[`CTL_CFG_SEL] &
                  (op_state == op_idle);
   assign go_data = ~wbyte[`CTL_CFG_SEL] & ~wbyte[`CTL_PROG_SEL];
   assign done = (op_state == op_program) & (timer_reg == 16'h0000) & ce_in;
   assign events = {wr_bad, done};
   assign rd_byte = mem[addr_reg];
   assign key_first = wr_acc & sel_unlock & (wbyte == `UNLOCK_KEY_FIRST);
   assign key_second = wr_acc & sel_unlock & (wbyte == `UNLOCK_KEY_SECOND);

   // unlock sequencer: keys must arrive in consecutive bus transfers
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         ul_state <= ul_idle;
      end else if (acc) begin
         case (ul_state)
            ul_idle: ul_state <= key_first ? ul_first : ul_idle;
            ul_first: ul_state <= key_second ? ul_armed :
                                  (key_first ? ul_first : ul_idle);
            ul_armed: ul_state <= key_first ? ul_first : ul_idle;
            default: ul_state <= ul_idle;
         endcase
      end
   end

   // self-timed erase then program for the data store, program only otherwise
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         op_state <= op_idle;
         timer_reg <= 16'h0000;
         op_addr_reg <= `REG_RESET;
         op_data_reg <= `REG_RESET;
         op_data_space_reg <= 1'b0;
      end else if (ce_in) begin
         case (op_state)
            op_idle: begin
               if (wr_go) begin
                  op_addr_reg <= addr_reg;
                  op_data_reg <= data_reg;
                  op_data_space_reg <= go_data;
                  if (go_data) begin
                     op_state <= op_erase;
                     timer_reg <= 16'(`ERASE_CYCLES - 1);
                  end else begin
                     op_state <= op_program;
                     timer_reg <= 16'(`PROG_CYCLES - 1);
                  end
               end
            end
            op_erase: begin
               if (timer_reg == 16'h0000) begin
                  op_state <= op_program;
                  timer_reg <= 16'(`PROG_CYCLES - 1);
               end else begin
                  timer_reg <= timer_reg - 16'h0001;
               end
            end
            op_program: begin
               if (timer_reg == 16'h0000) begin
                  op_state <= op_idle;
               end else begin
                  timer_reg <= timer_reg - 16'h0001;
               end
            end
            default: op_state <= op_idle;
         endcase
      end
   end

   // data store array, not cleared by reset
   always_ff @(posedge clk_in) begin
      if (ce_in && op_data_space_reg) begin
         if (op_state == op_erase && timer_reg == 16'h0000) begin
            mem[op_addr_reg] <= `ERASED_BYTE;
         end else if (done) begin
            mem[op_addr_reg] <= op_data_reg;
         end
      end
   end

   // control bits
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         prog_sel_reg <= 1'b0;
         cfg_sel_reg <= 1'b0;
         row_erase_reg <= 1'b0;
         wr_allow_reg <= 1'b0;
         wr_start_reg <= 1'b0;
         rd_start_reg <= 1'b0;
      end else if (ce_in) begin
         if (wr_acc & sel_ctl) begin
            prog_sel_reg <= wbyte[`CTL_PROG_SEL];
            cfg_sel_reg <= wbyte[`CTL_CFG_SEL];
            row_erase_reg <= wbyte[`CTL_ROW_ERASE];
            wr_allow_reg <= wbyte[`CTL_WR_ALLOW];
         end
         if (wr_go) begin
            wr_start_reg <= 1'b1;
         end else if (done) begin
            wr_start_reg <= 1'b0;
         end
         rd_start_reg <= rd_go;
      end
   end

   // error flag survives pin and watchdog resets; of the resets, only power-up clears it
   always_ff @(posedge clk_in or negedge por_n_in) begin
      if (!por_n_in) begin
         wr_err_reg <= 1'b0;
      end else if (ce_in) begin
         if (wr_go | wr_bad) begin
            wr_err_reg <= 1'b1;
         end else if (done) begin
            wr_err_reg <= 1'b0;
         end else if (wr_acc & sel_ctl) begin
            wr_err_reg <= wbyte[`CTL_WR_ERR];
         end
      end
   end

   // data and address registers
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         data_reg <= `REG_RESET;
         addr_reg <= `REG_RESET;
      end else if (ce_in) begin
         if (rd_start_reg) begin
            data_reg <= rd_byte;
         end else if (wr_acc & sel_data) begin
            data_reg <= wbyte;
         end
         if (wr_acc & sel_addr) begin
            addr_reg <= wbyte;
         end
      end
   end

   // cpu interrupt and table registers
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         core_reg <= `REG_RESET;
         prio_reg <= `REG_RESET;
         en2_reg <= `REG_RESET;
         flag2_reg <= `REG_RESET;
         tlat_reg <= `REG_RESET;
         plow_reg <= `REG_RESET;
         phigh_reg <= `REG_RESET;
         pup_reg <= `REG_RESET;
      end else if (ce_in) begin
         if (wr_acc & sel_core) core_reg <= wbyte;
         if (wr_acc & sel_prio) prio_reg <= wbyte & `IRQ2_IMPL_MASK;
         if (wr_acc & sel_en2) en2_reg <= wbyte & `IRQ2_IMPL_MASK;
         flag2_reg <= (wr_acc & sel_flag2) ? (wbyte & `IRQ2_IMPL_MASK) :
                      flag2_reg;
         if (done) begin
            flag2_reg[`IRQ2_WRITE_DONE] <= 1'b1;
         end
         if (wr_acc & sel_tlat) tlat_reg <= wbyte;
         if (wr_acc & sel_plow) plow_reg <= wbyte;
         if (wr_acc & sel_phigh) phigh_reg <= wbyte;
         if (wr_acc & sel_pup) pup_reg <= wbyte & `PTR_UPPER_MASK;
      end
   end

   // sticky event status, write one to clear, set wins
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         stat_reg <= 2'b00;
         mask_reg <= 2'b00;
      end else if (ce_in) begin
         stat_reg <= (stat_reg & ~((wr_acc & sel_stat) ? wbyte[1:0] : 2'b00))
                     | events;
         if (wr_acc & sel_mask) mask_reg <= wbyte[1:0];
      end
   end

   assign irq_out = |(stat_reg & mask_reg);
   assign write_done_cond = flag2_reg[`IRQ2_WRITE_DONE] &
                            en2_reg[`IRQ2_WRITE_DONE];
   assign irq_high_out = write_done_cond & prio_reg[`IRQ2_WRITE_DONE] &
                         core_reg[`CORE_GLOBAL_EN];
   assign irq_low_out = write_done_cond & ~prio_reg[`IRQ2_WRITE_DONE] &
                        core_reg[`CORE_GLOBAL_EN] &
                        core_reg[`CORE_PERIPH_EN];

   // program flash and configuration port
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         stall_reg <= 1'b0;
         pwr_reg <= 1'b0;
         perase_reg <= 1'b0;
         pcfg_reg <= 1'b0;
         paddr_reg <= 22'h000000;
         pdata_reg <= `REG_RESET;
      end else if (ce_in) begin
         pwr_reg <= wr_go & ~go_data;
         if (wr_go & ~go_data) begin
            stall_reg <= 1'b1;
            perase_reg <= wbyte[`CTL_ROW_ERASE];
            pcfg_reg <= wbyte[`CTL_CFG_SEL];
            paddr_reg <= {pup_reg[5:0], phigh_reg, plow_reg};
            pdata_reg <= tlat_reg;
         end else if (done) begin
            stall_reg <= 1'b0;
         end
      end
   end

   assign cpu_stall_out = stall_reg;
   assign prog_wr_out = pwr_reg;
   assign prog_erase_out = perase_reg;
   assign prog_cfg_out = pcfg_reg;
   assign prog_addr_out = paddr_reg;
   assign prog_data_out = pdata_reg;

   // read data captured in the setup cycle
   always_comb begin
      rbyte = 8'h00;
      case (1'b1)
         sel_ctl: rbyte = {prog_sel_reg, cfg_sel_reg, 1'b0, row_erase_reg,
                           wr_err_reg, wr_allow_reg, wr_start_reg,
                           rd_start_reg};
         sel_unlock: rbyte = 8'h00;
         sel_data: rbyte = data_reg;
         sel_addr: rbyte = addr_reg;
         sel_core: rbyte = core_reg;
         sel_prio: rbyte = prio_reg;
         sel_en2: rbyte = en2_reg;
         sel_flag2: rbyte = flag2_reg;
         sel_tlat: rbyte = tlat_reg;
         sel_plow: rbyte = plow_reg;
         sel_phigh: rbyte = phigh_reg;
         sel_pup: rbyte = pup_reg;
         sel_stat: rbyte = {6'h00, stat_reg};
         sel_mask: rbyte = {6'h00, mask_reg};
         default: rbyte = 8'h00;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         prdata_reg <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata_reg <= {24'h000000, rbyte};
      end
   end

   assign prdata_out = prdata_reg;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n);
   sequence s_unlock_armed;
      (ul_state == ul_armed) && wr_allow_reg;
   endsequence
   sequence s_start_taken;
      wr_start_reg && wr_err_reg;
   endsequence

   AST_UNLOCK_GATE:
      assert property ($rose(wr_start_reg) |-> $past(ul_state) == ul_armed
                       && $past(wr_allow_reg))
      else $error("write started without unlock");
   AST_START_SEQ:
      assert property (s_unlock_armed ##0 (wr_req && ce_in) |=> s_start_taken)
      else $error("armed write start not taken with error flag");
   AST_ERR_CLEAR:
      assert property (done |=> !wr_err_reg && !wr_start_reg)
      else $error("completion did not clear flags");
   AST_BAD_WRITE:
      assert property (wr_bad |=> wr_err_reg && !wr_start_reg &&
                       stat_reg[`STAT_WRITE_REJECT])
      else $error("improper write not flagged");
   AST_READ_DATA:
      assert property (rd_go |=> rd_start_reg ##1 (!rd_start_reg &&
                       data_reg == $past(rd_byte)))
      else $error("read data not loaded next cycle");
   AST_READ_BLOCKED:
      assert property (wr_acc && sel_ctl && wbyte[`CTL_RD_START] &&
                       wbyte[`CTL_PROG_SEL] |=> !rd_start_reg)
      else $error("read start set in program space");
   AST_ERASE_FIRST:
      assert property ($rose(op_state == op_erase) |->
                       timer_reg == 16'(`ERASE_CYCLES - 1))
      else $error("erase timer not loaded");
   AST_ERASED_BYTE:
      assert property (op_state == op_erase && timer_reg == 16'h0000 &&
                       ce_in |=> op_state == op_program &&
                       mem[op_addr_reg] == `ERASED_BYTE)
      else $error("location not erased before program");
   AST_DONE_FLAG:
      assert property (done |=> flag2_reg[`IRQ2_WRITE_DONE] &&
                       stat_reg[`STAT_WRITE_DONE])
      else $error("write done flag not set");
   AST_UNLOCK_READ:
      assert property (rd_setup && sel_unlock |=> prdata_out == 32'h0)
      else $error("unlock port read not zero");
   AST_PRIO_ROUTE:
      assert property ((irq_high_out |-> prio_reg[`IRQ2_WRITE_DONE]) and
                       (irq_low_out |-> !prio_reg[`IRQ2_WRITE_DONE]))
      else $error("interrupt priority routing wrong");
   AST_CFG_ROUTE:
      assert property (wr_go && wbyte[`CTL_CFG_SEL] |=> prog_wr_out &&
                       prog_cfg_out && op_state == op_program)
      else $error("config write not routed");
   AST_DATA_ROUTE:
      assert property (wr_go && go_data |=> op_state == op_erase &&
                       !prog_wr_out)
      else $error("data store write not routed");
   AST_WR_HOLD:
      assert property (wr_start_reg && !done |=> wr_start_reg)
      else $error("write start cleared early");

endmodule

/* File: rtl/nvm_access_defines.svh */
// What this block does
// - pin or watchdog reset during a write leaves the error flag set
// - byte-wide data store, 8-bit address 00h to FFh, 8-bit data register
// - a data byte write erases the location first, then programs it
// - write length set by an internal self-timer; hardware signals the end
// - config select clear: program select picks data store or flash
// - with config select set, operations target configuration space
// - writes only while write allow is set; write allow clears at power-up
// - error flag set with write start, cleared when the timer ends normally
// - software may set write start but never clear it; hardware clears it
// - write completion sets the write done flag; firmware clears it
// - read start begins a read, write start an erase/write; both self-clear
// - read start ignored while program select is set
// - unlock port has no storage and reads as zero
// - read data appears in the data register next cycle and is held
`ifndef NVM_ACCESS_DEFINES_SVH
`define NVM_ACCESS_DEFINES_SVH

`define OFF_CONTROL 8'h00
`define OFF_UNLOCK 8'h04
`define OFF_DATA 8'h08
`define OFF_ADDR 8'h0C
`define OFF_CORE_IRQ 8'h10
`define OFF_PRIO_TWO 8'h14
`define OFF_ENABLE_TWO 8'h18
`define OFF_FLAG_TWO 8'h1C
`define OFF_TABLE_LATCH 8'h20
`define OFF_PTR_LOW 8'h24
`define OFF_PTR_HIGH 8'h28
`define OFF_PTR_UPPER 8'h2C
`define OFF_IRQ_STATUS 8'h30
`define OFF_IRQ_MASK 8'h34

`define CTL_PROG_SEL 7
`define CTL_CFG_SEL 6
`define CTL_ROW_ERASE 4
`define CTL_WR_ERR 3
`define CTL_WR_ALLOW 2
`define CTL_WR_START 1
`define CTL_RD_START 0

`define CORE_GLOBAL_EN 7
`define CORE_PERIPH_EN 6
`define IRQ2_WRITE_DONE 4
`define IRQ2_IMPL_MASK 8'hFA
`define PTR_UPPER_MASK 8'h3F

`define STAT_WRITE_DONE 0
`define STAT_WRITE_REJECT 1

`define UNLOCK_KEY_FIRST 8'h55
`define UNLOCK_KEY_SECOND 8'hAA
`define ERASED_BYTE 8'hFF
`define REG_RESET 8'h00

`define CLK_PERIOD_NS 5
`define ERASE_TIME_NS 1000
`define PROG_TIME_NS 1000
`define ERASE_CYCLES ((`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_CYCLES ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: rtl/nvm_access_pkg.sv */
package nvm_access_pkg;
   typedef enum logic [1:0] {op_idle, op_erase, op_program} op_state_e;
   typedef enum logic [1:0] {ul_idle, ul_first, ul_armed} unlock_state_e;
endpackage

/* File: verif/nvm_fw_model.sv */
`timescale 1ns/100ps
`include "nvm_access_defines.svh"
module nvm_fw_model (
   input wire logic clk_in,
   input wire logic pready_in,
   input wire logic pslverr_in,
   input wire logic [31:0] prdata_in,
   output logic psel_out,
   output logic penable_out,
   output logic pwrite_out,
   output logic [7:0] paddr_out,
   output logic [31:0] pwdata_out
);
   logic last_err;
   logic [7:0] last_rd;
   initial begin
      psel_out = 1'b0;
      penable_out = 1'b0;
      pwrite_out = 1'b0;
      paddr_out = 8'h00;
      pwdata_out = 32'h00000000;
      last_err = 1'b0;
      last_rd = 8'h00;
   end
   // one transfer, request held until pready
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
      @(posedge clk_in);
      psel_out <= 1'b1;
      penable_out <= 1'b0;
      pwrite_out <= w;
      paddr_out <= a;
      pwdata_out <= {24'h000000, d};
      @(posedge clk_in);
      penable_out <= 1'b1;
      do begin
         @(posedge clk_in);
      end while (pready_in !== 1'b1);
      last_err = pslverr_in;
      last_rd = prdata_in[7:0];
      psel_out <= 1'b0;
      penable_out <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      xfer(1'b0, a, 8'h00);
   endtask
   // cpu interrupts off, both keys, then the start write
   task automatic start_write(input logic [7:0] ctl);
      wr(`OFF_CORE_IRQ, 8'h00);
      wr(`OFF_UNLOCK, `UNLOCK_KEY_FIRST);
      wr(`OFF_UNLOCK, `UNLOCK_KEY_SECOND);
      wr(`OFF_CONTROL, ctl);
   endtask
endmodule

/* File: verif/nvm_eeprom_access_control_bench.sv */
`timescale 1ns/100ps
`include "nvm_access_defines.svh"
module nvm_eeprom_access_control_bench;
   logic clk_in, arst_n, por_n, ce, psel, pen, pwr_en, pslverr, pready;
   logic irq, irq_hi, irq_lo, stall, pwr, perase, pcfg;
   logic [7:0] paddr, a, d, cap_cfg, cap_er, cap_data;
   logic [31:0] pwdata, prdata;
   logic [21:0] paddr_p, cap_addr;
   logic [7:0] pdata_p;
   logic [7:0] mem_m [256];
   logic [7:0] addr_q [$];
   logic [7:0] ctl_t [4] = '{8'h86, 8'h96, 8'hC6, 8'h46};
   int mismatches, checks_done, cyc, seed, pw_cnt, stall_cyc, k;
   nvm_access_ctrl dut_u (.clk_in(clk_in), .arst_n_in(arst_n),
      .por_n_in(por_n), .ce_in(ce), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr_en), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .irq_out(irq), .irq_high_out(irq_hi), .irq_low_out(irq_lo),
      .cpu_stall_out(stall), .prog_wr_out(pwr), .prog_erase_out(perase),
      .prog_cfg_out(pcfg), .prog_addr_out(paddr_p),
      .prog_data_out(pdata_p));
   nvm_fw_model fw_u (.clk_in(clk_in), .pready_in(pready),
      .pslverr_in(pslverr), .prdata_in(prdata), .psel_out(psel),
      .penable_out(pen), .pwrite_out(pwr_en), .paddr_out(paddr),
      .pwdata_out(pwdata));
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   task complete_run;
      if (mismatches == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp);
      fw_u.rd(ad);
      chk(fw_u.last_rd, exp);
   endtask
   task automatic wait_done();
      do begin
         fw_u.rd(`OFF_CONTROL);
      end while (fw_u.last_rd[`CTL_WR_START] !== 1'b0);
   endtask
   // program-side pulse capture and stall count
   always @(posedge clk_in) begin
      cyc++;
      if (pwr === 1'b1) begin
         pw_cnt++;
         cap_cfg = {7'h00, pcfg};
         cap_er = {7'h00, perase};
         cap_addr = paddr_p;
         cap_data = pdata_p;
      end
      if (stall === 1'b1)
         stall_cyc++;
      if (cyc == 20000) begin
         mismatches++;
         $display("mismatch at %0t: run timed out", $time);
         complete_run();
      end
   end
   initial begin
      arst_n = 1'b0;
      por_n = 1'b0;
      ce = 1'b1;
      seed = 55;
      mismatches = 0;
      checks_done = 0;
      cyc = 0;
      pw_cnt = 0;
      stall_cyc = 0;
      repeat (6) @(posedge clk_in);
      arst_n <= 1'b1;
      por_n <= 1'b1;
      for (k = 0; k <= 'h34; k += 4) begin
         rd_chk(k[7:0], `REG_RESET);
      end
      fw_u.wr(`OFF_UNLOCK, 8'h5A);
      rd_chk(`OFF_UNLOCK, 8'h00);
      fw_u.wr(`OFF_IRQ_MASK, 8'h03);
      fw_u.start_write(8'h02);
      rd_chk(`OFF_CONTROL, 8'h08);
      rd_chk(`OFF_IRQ_STATUS, 8'h02);
      @(negedge clk_in);
      chk({7'h00, irq}, 8'h01);
      fw_u.wr(`OFF_IRQ_STATUS, 8'h02);
      @(negedge clk_in);
      chk({7'h00, irq}, 8'h00);
      // keys split by another transfer
      fw_u.wr(`OFF_CONTROL, 8'h04);
      fw_u.wr(`OFF_UNLOCK, `UNLOCK_KEY_FIRST);
      fw_u.wr(`OFF_DATA, 8'h00);
      fw_u.wr(`OFF_UNLOCK, `UNLOCK_KEY_SECOND);
      fw_u.wr(`OFF_CONTROL, 8'h06);
      rd_chk(`OFF_CONTROL, 8'h0C);
      fw_u.wr(`OFF_IRQ_STATUS, 8'h03);
      for (k = 0; k < 3; k++) begin
         a = (k == 2) ? 8'hFF : 8'($random(seed));
         d = 8'($random(seed));
         fw_u.wr(`OFF_ADDR, a);
         fw_u.wr(`OFF_DATA, d);
         fw_u.start_write(8'h06);
         mem_m[a] = d;
         addr_q.push_back(a);
         rd_chk(`OFF_CONTROL, 8'h0E);
         fw_u.wr(`OFF_CONTROL, 8'h0C);
         rd_chk(`OFF_CONTROL, 8'h0E);
         wait_done();
         rd_chk(`OFF_CONTROL, 8'h04);
         rd_chk(`OFF_FLAG_TWO, 8'h10);
         rd_chk(`OFF_IRQ_STATUS, 8'h01);
         fw_u.wr(`OFF_CORE_IRQ, 8'hC0);
         fw_u.wr(`OFF_ENABLE_TWO, 8'h10);
         fw_u.wr(`OFF_PRIO_TWO, {3'h0, k[0], 4'h0});
         @(negedge clk_in);
         chk({6'h00, irq_hi, irq_lo}, k[0] ? 8'h02 : 8'h01);
         fw_u.wr(`OFF_FLAG_TWO, 8'h00);
         fw_u.wr(`OFF_IRQ_STATUS, 8'h01);
         @(negedge clk_in);
         chk({5'h00, irq_hi, irq_lo, irq}, 8'h00);
      end
      chk(8'(stall_cyc > 0), 8'h00);
      foreach (addr_q[i]) begin
         fw_u.wr(`OFF_ADDR, addr_q[i]);
         fw_u.wr(`OFF_CONTROL, 8'h05);
         rd_chk(`OFF_DATA, mem_m[addr_q[i]]);
         rd_chk(`OFF_CONTROL, 8'h04);
      end
      fw_u.wr(`OFF_DATA, 8'h3C);
      fw_u.wr(`OFF_CONTROL, 8'h85);
      rd_chk(`OFF_CONTROL, 8'h84);
      rd_chk(`OFF_DATA, 8'h3C);
      fw_u.wr(`OFF_PTR_LOW, 8'h34);
      fw_u.wr(`OFF_PTR_HIGH, 8'h12);
      fw_u.wr(`OFF_PTR_UPPER, 8'hFF);
      fw_u.wr(`OFF_TABLE_LATCH, 8'hA5);
      for (k = 0; k < 4; k++) begin
         pw_cnt = 0;
         stall_cyc = 0;
         fw_u.start_write(ctl_t[k]);
         wait_done();
         chk(8'(pw_cnt), 8'h01);
         chk(cap_cfg, {7'h00, ctl_t[k][6]});
         chk(cap_er, {7'h00, ctl_t[k][4]});
         chk(8'(stall_cyc >= `PROG_CYCLES - 1), 8'h01);
         chk(8'(cap_addr == 22'h3F1234), 8'h01);
         chk(cap_data, 8'hA5);
      end
      fw_u.rd(8'h3C);
      chk({7'h00, fw_u.last_err}, 8'h01);
      chk(fw_u.last_rd, 8'h00);
      // pin reset in mid-write
      fw_u.wr(`OFF_ADDR, 8'h10);
      fw_u.start_write(8'h06);
      // clock enable low must freeze the running write
      ce <= 1'b0;
      repeat (500) @(posedge clk_in);
      ce <= 1'b1;
      rd_chk(`OFF_CONTROL, 8'h0E);
      repeat (20) @(posedge clk_in);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk_in);
      arst_n <= 1'b1;
      rd_chk(`OFF_CONTROL, 8'h08);
      complete_run();
   end
endmodule
